// file: hw/brwc_pkg.sv
// Package: constants, configuration carrier and states for the ready wait control
package brwc_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int REF_DIV = 2;
   localparam int REF_PERIOD_NS = CLK_PERIOD_NS * REF_DIV;
   // ---------------------------------------------------------------
   // Access phase limits, in reference clock periods
   // ---------------------------------------------------------------
   localparam int AWS_W = 6;
   localparam logic [AWS_W-1:0] AWS_MIN = 6'h01;
   localparam logic [AWS_W-1:0] AWS_MAX = 6'h20;
   localparam logic [AWS_W-1:0] AWS_LAST = 6'h01;
   // ---------------------------------------------------------------
   // Counters, synchroniser and reset values
   // ---------------------------------------------------------------
   localparam int WS_W = 8;
   localparam logic [WS_W-1:0] WS_ONE = 8'h01;
   localparam int SYNC_LEN = 3;
   localparam logic [SYNC_LEN-1:0] SYNC_RST = 3'h0;
   localparam logic REF_RST = 1'h0;
   localparam logic CMD_IDLE = 1'h1;
   // ---------------------------------------------------------------
   // Cycle configuration
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [AWS_W-1:0] access_ws; // Mandatory access phase length
      logic rdy_en;                // Cycle is ready controlled
      logic rdy_pol;               // Level that means ready
      logic rdy_async;             // Ready passes the synchroniser
      logic is_read;               // Read cycle, else write
   } brwc_cfg_s;
   localparam brwc_cfg_s CFG_RST = '{access_ws: AWS_MIN, rdy_en: 1'h0, rdy_pol: 1'h0,
                                     rdy_async: 1'h0, is_read: 1'h0};
   typedef enum logic [1:0] {ST_IDLE, ST_ALIGN, ST_ACCESS, ST_WAIT} brwc_state_e;
endpackage

// file: hw/brwc_ctrl.sv
// Ready controlled wait state logic of the external bus cycle
// Operation
// - Ready polarity is selectable per cycle; either level may mean ready.
// - Synchronous ready gives the shortest cycle; partner drives it on the reference clock.
// - Asynchronous ready passes an extra synchroniser, adding at least one waitstate.
// - Ready inactive at a sample point inserts a waitstate and samples again.
// - Ready active at a sample point ends the running bus cycle.
// - Asynchronous sample point lies one reference period after the synchronous one.
// - Ready is ignored until the mandatory access waitstates have elapsed.
// - Read data is latched on the edge that raises the read strobe.
module brwc_ctrl
   import brwc_pkg::*;
#(
   parameter int DW = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Cycle request
   input wire logic start,
   input wire brwc_cfg_s cfg,
   // Bus pins
   input wire logic ready_pin,
   input wire logic [DW-1:0] rd_data_pin,
   output logic bus_reference_clock_out,
   output logic rd_n,
   output logic wr_n,
   // User side answer
   output logic busy,
   output logic done,
   output logic [DW-1:0] rd_data,
   output logic [WS_W-1:0] ws_count
);
   // ---------------------------------------------------------------
   // Parameter check
   // ---------------------------------------------------------------
   if (DW < 1) begin : g_bad_dw
      $error("DW must be at least 1");
   end

   // ---------------------------------------------------------------
   // Reference clock and asynchronous ready synchroniser
   // ---------------------------------------------------------------
   logic ref_clk;
   logic next_ref_clk;
   logic [SYNC_LEN-1:0] sync;
   logic [SYNC_LEN-1:0] next_sync;
   logic async_lvl;
   logic next_async_lvl;
   logic tick;

   // Tick marks the edge on which the reference clock rises
   assign tick = ~ref_clk;

   // Divider, shift chain and agreement filter
   always_comb begin
      next_ref_clk = ~ref_clk;
      next_sync = {sync[SYNC_LEN-2:0], ready_pin};
      next_async_lvl = async_lvl;
      if (sync[1] == sync[2]) begin
         next_async_lvl = sync[2];
      end
   end

   // Register reference and synchroniser state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ref_clk <= REF_RST;
         sync <= SYNC_RST;
         async_lvl <= 1'h0;
      end else begin
         ref_clk <= next_ref_clk;
         sync <= next_sync;
         async_lvl <= next_async_lvl;
      end
   end

   // ---------------------------------------------------------------
   // Cycle sequencer
   // ---------------------------------------------------------------
   brwc_state_e state;
   brwc_state_e next_state;
   brwc_cfg_s cfg_q;
   brwc_cfg_s next_cfg_q;
   logic [AWS_W-1:0] cnt;
   logic [AWS_W-1:0] next_cnt;
   logic skip;
   logic next_skip;
   logic next_rd_n;
   logic next_wr_n;
   logic next_busy;
   logic next_done;
   logic [DW-1:0] next_rd_data;
   logic [WS_W-1:0] next_ws_count;
   logic rdy_act;

   // shortest sync path, no extra stage
   // selectable polarity; sync mode reads the pin directly
   assign rdy_act = cfg_q.rdy_async ? (async_lvl == cfg_q.rdy_pol) : (ready_pin == cfg_q.rdy_pol);

   // Next values of the sequencer
   always_comb begin
      next_state = state;
      next_cfg_q = cfg_q;
      next_cnt = cnt;
      next_skip = skip;
      next_rd_n = rd_n;
      next_wr_n = wr_n;
      next_done = 1'h0;
      next_rd_data = rd_data;
      next_ws_count = ws_count;
      unique case (state)
         ST_IDLE: begin
            if (start) begin
               next_cfg_q = cfg;
               next_cnt = (cfg.access_ws == '0) ? AWS_MIN : cfg.access_ws;
               next_ws_count = '0;
               next_state = ST_ALIGN;
            end
         end
         ST_ALIGN: begin
            // Command falls with the rising reference clock
            if (tick) begin
               next_rd_n = ~cfg_q.is_read;
               next_wr_n = cfg_q.is_read;
               next_state = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            if (tick) begin
               if (cnt != AWS_LAST) begin
                  next_cnt = cnt - AWS_LAST;
               end else if (cfg_q.rdy_en) begin
                  // asynchronous sample point one period later
                  next_skip = cfg_q.rdy_async;
                  next_state = ST_WAIT;
               end else begin
                  next_state = ST_IDLE;
               end
            end
         end
         ST_WAIT: begin
            if (tick) begin
               if (skip) begin
                  next_skip = 1'h0;
                  next_ws_count = ws_count + WS_ONE;
               end else if (rdy_act) begin
                  next_state = ST_IDLE;
               end else begin
                  next_ws_count = ws_count + WS_ONE;
               end
            end
         end
      endcase
      // end of cycle raises strobe and latches read data together
      if (state != ST_IDLE && state != ST_ALIGN && next_state == ST_IDLE) begin
         next_rd_n = CMD_IDLE;
         next_wr_n = CMD_IDLE;
         next_done = 1'h1;
         if (cfg_q.is_read) begin
            next_rd_data = rd_data_pin;
         end
      end
      next_busy = (next_state != ST_IDLE);
   end

   // Register sequencer state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         cfg_q <= CFG_RST;
         cnt <= AWS_MIN;
         skip <= 1'h0;
         rd_n <= CMD_IDLE;
         wr_n <= CMD_IDLE;
         busy <= 1'h0;
         done <= 1'h0;
         rd_data <= '0;
         ws_count <= '0;
      end else begin
         state <= next_state;
         cfg_q <= next_cfg_q;
         cnt <= next_cnt;
         skip <= next_skip;
         rd_n <= next_rd_n;
         wr_n <= next_wr_n;
         busy <= next_busy;
         done <= next_done;
         rd_data <= next_rd_data;
         ws_count <= next_ws_count;
      end
   end

   assign bus_reference_clock_out = ref_clk;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   polarity_gate_a:
      assert property (@(posedge clk) disable iff (!rst_n)
         (state == ST_WAIT && tick && !skip && !cfg_q.rdy_async && ready_pin != cfg_q.rdy_pol) |=> !done)
      else $error("ready of wrong polarity ended the cycle");
   sync_shortest_a:
      assert property (@(posedge clk) disable iff (!rst_n)
         (state == ST_ACCESS && tick && cnt == AWS_LAST && cfg_q.rdy_en && !cfg_q.rdy_async)
         ##2 (ready_pin == cfg_q.rdy_pol) |=> done)
      else $error("synchronous ready did not end the cycle at the first sample");
   async_extra_a:
      assert property (@(posedge clk) disable iff (!rst_n)
         (state == ST_ACCESS && tick && cnt == AWS_LAST && cfg_q.rdy_en && cfg_q.rdy_async)
         |=> (!done && state == ST_WAIT) [*3])
      else $error("asynchronous ready skipped its synchroniser waitstate");
   filter_agree_a:
      assert property (@(posedge clk) disable iff (!rst_n)
         (async_lvl != $past(async_lvl)) |-> ($past(sync[1]) == $past(sync[2])))
      else $error("asynchronous level changed without agreement");
   notready_wait_a:
      assert property (@(posedge clk) disable iff (!rst_n)
         (state == ST_WAIT && tick && !skip && !rdy_act)
         |=> (state == ST_WAIT && ws_count == $past(ws_count) + WS_ONE))
      else $error("not ready did not insert a waitstate");
   ready_finish_a:
      assert property (@(posedge clk) disable iff (!rst_n)
         (state == ST_WAIT && tick && !skip && rdy_act) |=> (done && rd_n && wr_n && state == ST_IDLE))
      else $error("ready did not end the cycle");
   mandatory_hold_a:
      assert property (@(posedge clk) disable iff (!rst_n)
         (state == ST_ACCESS && tick && cnt != AWS_LAST) |=> (state == ST_ACCESS) ##1 (state == ST_ACCESS))
      else $error("access phase left before mandatory waitstates");
   read_latch_a:
      assert property (@(posedge clk) disable iff (!rst_n)
         (done && !$past(rd_n)) |-> (rd_n && rd_data == $past(rd_data_pin)))
      else $error("read data not latched on strobe rise");
   sync_direct_a:
      assert property (@(posedge clk) disable iff (!rst_n)
         (state == ST_WAIT && tick && !cfg_q.rdy_async && ready_pin == cfg_q.rdy_pol) |=> done)
      else $error("synchronous ready not sampled directly");
endmodule

// file: tb/brwc_ready_model.sv
// Model of the external circuit that answers ready and read data
module brwc_ready_model
   import brwc_pkg::*;
#(
   parameter int DW = 16
) (
   // Bus side
   input wire logic bus_reference_clock_out,
   input wire logic rd_n,
   input wire logic wr_n,
   output logic ready_pin,
   output logic [DW-1:0] rd_data_pin,
   // Scenario control
   input wire logic pol,
   input wire logic [7:0] thresh,
   input wire logic [DW-1:0] data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt;
   logic [DW-1:0] last;

   // Quiet values at time zero
   initial begin
      cnt = 8'h00;
      last = '0;
      ready_pin = 1'h0;
      rd_data_pin = '0;
   end

   // ready held till strobe rises, driven off the reference clock
   always @(posedge bus_reference_clock_out) begin
      #1;
      if (rd_n === 1'h0 || wr_n === 1'h0) begin
         cnt = cnt + 8'h01;
      end else begin
         cnt = 8'h00;
      end
      ready_pin = (cnt != 8'h00 && cnt >= thresh) ? pol : ~pol;
   end

   // Read data valid while the read strobe is low, inverted once released
   always @(rd_n or data) begin
      if (rd_n === 1'h0) begin
         rd_data_pin = data;
         last = data;
      end else begin
         rd_data_pin = ~last;
      end
   end
endmodule

// file: tb/bus_ready_wait_control_test.sv
// Self-checking bench for the ready controlled wait state logic
module bus_ready_wait_control_test
   import brwc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, start, ready_pin, ref_clk, rd_n, wr_n, busy, done;
   brwc_cfg_s cfg;
   logic [15:0] rd_data_pin, rd_data, data;
   logic [WS_W-1:0] ws_count;
   logic [7:0] thresh;
   int bad_count, n_compared;

   brwc_ctrl #(.DW(16)) dut_u (.clk(clk), .rst_n(rst_n), .start(start), .cfg(cfg), .ready_pin(ready_pin),
      .rd_data_pin(rd_data_pin), .bus_reference_clock_out(ref_clk), .rd_n(rd_n), .wr_n(wr_n), .busy(busy),
      .done(done), .rd_data(rd_data), .ws_count(ws_count));
   brwc_ready_model #(.DW(16)) model_u (.bus_reference_clock_out(ref_clk), .rd_n(rd_n), .wr_n(wr_n),
      .ready_pin(ready_pin), .rd_data_pin(rd_data_pin), .pol(cfg.rdy_pol), .thresh(thresh), .data(data));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic check(input logic ok, input string what);
      n_compared++;
      if (ok !== 1'h1) begin
         bad_count++;
         $display("BAD at %0t: %s", $time, what);
      end
   endtask

   // Ready controlled waitstates expected in synchronous mode
   function automatic logic [WS_W-1:0] exp_ws(input logic [7:0] d, input logic early);
      return early ? 8'h00 : d;
   endfunction

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One bus cycle; start held two cycles so the second request must be ignored
   task automatic run(input logic [5:0] aws, input logic en, input logic p, input logic asy, input logic rd,
                      input logic [7:0] d, input logic early);
      int a, low, lim;
      logic other, quiet, prev_ref;
      logic [15:0] val, keep;
      logic [WS_W-1:0] e;
      a = (aws == 6'h00) ? 1 : int'(aws);
      val = 16'($urandom);
      e = exp_ws(d, early);
      other = 1'h0;
      @(posedge clk);
      #1;
      cfg = '{access_ws: aws, rdy_en: en, rdy_pol: p, rdy_async: asy, is_read: rd};
      data = val;
      thresh = early ? 8'h00 : 8'(a + int'(d) + 1);
      start = 1'h1;
      keep = rd_data;
      @(posedge clk);
      #1;
      // Start stays high one more edge with another length; the busy sequencer must ignore it
      cfg.access_ws = ~aws;
      quiet = 1'h0;
      prev_ref = ref_clk;
      low = 0;
      for (lim = 0; lim < 2000 && done !== 1'h1; lim++) begin
         @(posedge clk);
         #1;
         start = 1'h0;
         // Busy must stand until done; the reference clock toggles every edge
         if (done !== 1'h1 && busy !== 1'h1) begin
            quiet = 1'h1;
         end
         if (ref_clk === prev_ref) begin
            quiet = 1'h1;
         end
         prev_ref = ref_clk;
         if ((rd ? rd_n : wr_n) === 1'h0) begin
            low++;
         end
         if ((rd ? wr_n : rd_n) !== 1'h1) begin
            other = 1'h1;
         end
      end
      check(done === 1'h1 && busy === 1'h0 && other === 1'h0, "cycle end or strobes");
      check(quiet === 1'h0, "busy or reference clock");
      if (!en) begin
         check(ws_count === 8'h00 && low == 2 * a, "plain cycle length");
      end else if (!asy) begin
         check(ws_count === e && low == 2 * (a + int'(e) + 1), "sync wait length");
      end else begin
         check(ws_count >= e + 8'h01 && ws_count <= e + (early ? 8'h01 : 8'h02) &&
               low == 2 * (a + int'(ws_count) + 1), "async wait length");
      end
      if (rd) begin
         check(rd_data === val, "read data");
      end else begin
         check(rd_data === keep, "read data held over write");
      end
      $display("cycle done aws=%0d ready=%0b async=%0b ws=%0d", aws, en, asy, ws_count);
   endtask

   // ---------------------------------------------------------------
   // Clock, watchdog and sequence
   // ---------------------------------------------------------------
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   // Hang guard well beyond the longest run
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("BAD at %0t: watchdog expired", $time);
      report_and_stop();
   end

   // Reset, corner table, then random cycles
   initial begin
      rst_n = 1'h0;
      start = 1'h0;
      cfg = CFG_RST;
      data = 16'h0000;
      thresh = 8'h00;
      bad_count = 0;
      n_compared = 0;
      void'($urandom(76));
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'h1;
      check(rd_n === 1'h1 && wr_n === 1'h1 && busy === 1'h0 && ws_count === 8'h00, "reset state");
      for (int i = 0; i < 12; i++) begin
         run(i % 3 == 0 ? 6'h00 : (i % 3 == 1 ? 6'h01 : 6'h20), i % 4 != 3, i[0], i[1], i[2], 8'(i % 3),
             i[3]);
      end
      for (int i = 0; i < 20; i++) begin
         run(6'($urandom_range(32)), 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
             8'($urandom_range(4)), 1'($urandom));
      end
      report_and_stop();
   end
endmodule
